// >>> core/sepc_consts.vh
// constants for the shutdown/enable power control block
`ifndef SEPC_CONSTS_VH
`define SEPC_CONSTS_VH
`define SEPC_CLK_HZ 100000000
`define SEPC_QUAL_MS 500
`define SEPC_HARD_MS 10000
`define SEPC_QUAL_CYC ((`SEPC_CLK_HZ / 1000) * `SEPC_QUAL_MS)
`define SEPC_HARD_CYC ((`SEPC_CLK_HZ / 1000) * `SEPC_HARD_MS)
`define SEPC_CNT_W 32
`define SEPC_ST_ON 3'h0
`define SEPC_ST_DISC 3'h1
`define SEPC_ST_WAIT 3'h2
`define SEPC_ST_OFF 3'h3
`define SEPC_ST_HOLD 3'h4
`endif

// >>> core/sepc_sync_timer.v
// two-flop synchroniser with continuous-assertion duration counter
`timescale 1ns/1ns
module sepc_sync_timer #(
    parameter [31:0] LIMIT = 32'h0000_0001
) (
    input wire clk_sys_i,
    input wire rst_n_i,
    input wire async_i,
    output reg level_o,
    output reg reached_o
);
    reg meta_q;
    reg [31:0] cnt_q;

    always @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            meta_q <= 1'b0;
            level_o <= 1'b0;
            cnt_q <= 32'h0;
            reached_o <= 1'b0;
        end else begin
            meta_q <= async_i;
            level_o <= meta_q;
            // any drop restarts the count
            if (!level_o) begin
                cnt_q <= 32'h0;
                reached_o <= 1'b0;
            end else if (cnt_q < LIMIT) begin
                cnt_q <= cnt_q + 32'h1;
                reached_o <= (cnt_q + 32'h1 >= LIMIT);
            end
        end
    end
endmodule

// >>> core/sepc_power_ctrl.v
// shutdown/enable power control sequencer
// What this block does
// - after 0.5 s shutdown: disconnect, then power off
// - 10 s continuous shutdown forces hardware power-down
// - enable while powered down reapplies power
// - enable overrides shutdown qualification
// - enable holds power through undervoltage cutoff
// - cutoff feature disabled: shutdown cannot remove power
// - firmware cutoff settings ignored by shutdown
// - shutdown timing fixed, needs no configuration
// - shutdown level readable while powered
// - enable level readable as status
// - cutoff enabled exactly when switch is on
`timescale 1ns/1ns
`include "sepc_consts.vh"
module sepc_power_ctrl #(
    parameter [31:0] QUAL_CYC = `SEPC_QUAL_CYC,
    parameter [31:0] HARD_CYC = `SEPC_HARD_CYC
) (
    input wire clk_sys_i,
    input wire rst_n_i,
    input wire shutdown_req_i,
    input wire enable_req_i,
    input wire uvlo_sw_on_i,
    input wire uv_trip_i,
    input wire stacks_open_i,
    output reg disconnect_o,
    output reg power_on_o,
    output reg shutdown_state_o,
    output reg enable_state_o,
    output reg [2:0] state_o
);
    wire sd_lvl;
    wire sd_qual;
    wire sd_hard;
    wire en_lvl;
    wire uvlo_lvl;
    wire uv_lvl;
    wire open_lvl;
    reg [2:0] st_q;
    reg [2:0] st_d;
    reg disc_d;
    reg pwr_d;

    localparam [2:0] ST_ON = 3'h0;
    localparam [2:0] ST_DISC = 3'h1;
    localparam [2:0] ST_WAIT = 3'h2;
    localparam [2:0] ST_OFF = 3'h3;
    localparam [2:0] ST_HOLD = 3'h4;

    // fixed thresholds, no software path into them
    sepc_sync_timer #(.LIMIT(QUAL_CYC)) u_sd_q (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .async_i(shutdown_req_i),
        .level_o(sd_lvl),
        .reached_o(sd_qual)
    );
    sepc_sync_timer #(.LIMIT(HARD_CYC)) u_sd_h (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .async_i(shutdown_req_i),
        .level_o(),
        .reached_o(sd_hard)
    );
    sepc_sync_timer #(.LIMIT(32'h1)) u_en (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .async_i(enable_req_i),
        .level_o(en_lvl),
        .reached_o()
    );
    sepc_sync_timer #(.LIMIT(32'h1)) u_uvlo (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .async_i(uvlo_sw_on_i),
        .level_o(uvlo_lvl),
        .reached_o()
    );
    sepc_sync_timer #(.LIMIT(32'h1)) u_uv (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .async_i(uv_trip_i),
        .level_o(uv_lvl),
        .reached_o()
    );
    sepc_sync_timer #(.LIMIT(32'h1)) u_open (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .async_i(stacks_open_i),
        .level_o(open_lvl),
        .reached_o()
    );

    // only the hardware switch and enable gate shutdown; no firmware setting enters
    wire sd_may_cut = uvlo_lvl & ~en_lvl;
    wire uv_cut = uvlo_lvl & uv_lvl & ~en_lvl;
    // reached flags clear one cycle after the level drops; mask that cycle
    wire sd_qual_ok = sd_qual & sd_lvl;
    wire sd_hard_ok = sd_hard & sd_lvl;

    always @* begin
        st_d = st_q;
        case (st_q)
            ST_ON: begin
                if (uv_cut || (sd_may_cut && sd_hard_ok))
                    st_d = ST_OFF;
                else if (sd_may_cut && sd_qual_ok)
                    st_d = ST_DISC;
            end
            ST_DISC: begin
                // enable or a switch turned off abandons the sequence
                if (!sd_may_cut)
                    st_d = ST_ON;
                else if (uv_cut || sd_hard_ok)
                    st_d = ST_OFF;
                else if (open_lvl)
                    st_d = ST_WAIT;
            end
            ST_WAIT: begin
                if (!sd_may_cut)
                    st_d = ST_ON;
                else
                    st_d = ST_OFF;
            end
            ST_OFF: begin
                if (en_lvl)
                    st_d = ST_HOLD;
            end
            ST_HOLD: begin
                // stay up until the request that cut power has gone, unless enable drops while a forced or undervoltage cut still applies
                if (!sd_lvl && !(uvlo_lvl && uv_lvl))
                    st_d = ST_ON;
                else if (!en_lvl && ((sd_may_cut && sd_hard_ok) || uv_cut))
                    st_d = ST_OFF;
            end
            default: st_d = ST_ON;
        endcase
    end

    always @* begin
        disc_d = 1'b0;
        pwr_d = 1'b1;
        case (st_d)
            ST_DISC: disc_d = 1'b1;
            ST_WAIT: disc_d = 1'b1;
            ST_OFF: pwr_d = 1'b0;
            default: begin
                disc_d = 1'b0;
                pwr_d = 1'b1;
            end
        endcase
    end

    always @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            st_q <= ST_ON;
            disconnect_o <= 1'b0;
            power_on_o <= 1'b1;
            shutdown_state_o <= 1'b0;
            enable_state_o <= 1'b0;
            state_o <= ST_ON;
        end else begin
            st_q <= st_d;
            state_o <= st_d;
            disconnect_o <= disc_d;
            power_on_o <= pwr_d;
            // held at zero once the unit is down: software cannot read it then
            shutdown_state_o <= sd_lvl & pwr_d;
            enable_state_o <= en_lvl;
        end
    end
endmodule

// >>> tb/sepc_power_ctrl_sva.sv
// port assertions for the power control sequencer
`timescale 1ns/1ns
`include "sepc_consts.vh"
module sepc_power_ctrl_sva #(parameter [31:0] QUAL_CYC = 20, parameter [31:0] HARD_CYC = 200) (
    input wire clk_sys_i, rst_n_i, shutdown_req_i, enable_req_i, uvlo_sw_on_i, uv_trip_i,
    input wire stacks_open_i, disconnect_o, power_on_o, shutdown_state_o, enable_state_o,
    input wire [2:0] state_o);
    logic [31:0] hi_q;
    // raw request age, so the synchroniser delay cannot hide a late start
    always_ff @(posedge clk_sys_i) hi_q <= (rst_n_i && shutdown_req_i) ? hi_q + 32'h1 : 32'h0;
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);
    sequence s_en; enable_req_i[*8]; endsequence
    sequence s_uv; (uv_trip_i && uvlo_sw_on_i && !enable_req_i)[*8]; endsequence
    // the switch reaches the state logic three edges after the pin
    a_sw_gate: assert property ($fell(power_on_o) |-> $past(uvlo_sw_on_i, 3))
        else $error("cut with switch off");
    a_en_blocks: assert property ($fell(power_on_o) |-> !enable_state_o)
        else $error("cut with enable");
    a_en_restore: assert property (s_en |-> power_on_o)
        else $error("enable not powering");
    a_disc_first: assert property (state_o == `SEPC_ST_WAIT |-> disconnect_o)
        else $error("wait without disconnect");
    a_disc_qual: assert property ($rose(disconnect_o) |-> hi_q >= QUAL_CYC)
        else $error("early disconnect");
    a_disc_late: assert property (hi_q == QUAL_CYC + 8 && uvlo_sw_on_i && !enable_state_o
        |-> disconnect_o || !power_on_o) else $error("late disconnect");
    a_hard_cut: assert property (hi_q == HARD_CYC + 8 && uvlo_sw_on_i && !enable_state_o
        |-> !power_on_o) else $error("no forced cut");
    a_en_status: assert property (enable_req_i[*6] |-> enable_state_o)
        else $error("enable status");
    a_sd_status: assert property (shutdown_req_i[*6] ##0 state_o == `SEPC_ST_ON
        |-> shutdown_state_o) else $error("shutdown status");
    a_uv_cut: assert property (s_uv |-> !power_on_o)
        else $error("no undervoltage cut");
endmodule
bind sepc_power_ctrl sepc_power_ctrl_sva #(.QUAL_CYC(QUAL_CYC), .HARD_CYC(HARD_CYC)) u_sva (.*);

// >>> tb/sepc_ctrl_model.sv
// far side: stack contactors opening some cycles after the disconnect command
`timescale 1ns/1ns
module sepc_ctrl_model (
    input wire clk_sys_i,
    input wire [31:0] dly_i,
    input wire disconnect_i,
    output logic stacks_open_o = 1'b0
);
    logic [31:0] cnt_q = 32'h0;
    always @(negedge clk_sys_i) begin
        cnt_q <= disconnect_i ? cnt_q + 32'h1 : 32'h0;
        stacks_open_o <= disconnect_i && cnt_q >= dly_i;
    end
endmodule

// >>> tb/shutdown_enable_power_control_tb.sv
// bench for the shutdown/enable power control block
`timescale 1ns/1ns
module shutdown_enable_power_control_tb;
    logic clk_sys_i = 0, rst_n_i = 0, shutdown_req_i = 0, enable_req_i = 0, uvlo_sw_on_i = 1;
    logic uv_trip_i = 0, stacks_open_i, disconnect_o, power_on_o, shutdown_state_o;
    logic enable_state_o;
    logic [2:0] state_o;
    logic [31:0] dly = 32'h2;
    int fails = 0, samples_checked = 0;
    sepc_power_ctrl #(.QUAL_CYC(20), .HARD_CYC(200)) dut (.*);
    sepc_ctrl_model far (.clk_sys_i, .dly_i(dly), .disconnect_i(disconnect_o),
        .stacks_open_o(stacks_open_i));
    initial forever #5 clk_sys_i = ~clk_sys_i;
    // bits: shutdown, enable, switch, undervoltage
    task drv(logic [3:0] v, int n);
        {shutdown_req_i, enable_req_i, uvlo_sw_on_i, uv_trip_i} = v;
        repeat (n) @(negedge clk_sys_i);
    endtask
    task chk(string s, logic e, logic g);
        samples_checked++;
        if (g !== e) begin
            fails++;
            $display("mismatch %s exp %b got %b", s, e, g);
        end
    endtask
    task stop_test;
        $display("checked %0d failed %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task t_seq;
        drv(4'ha, 10);
        drv(4'h2, 40);
        chk("pwr", 1, power_on_o);
        drv(4'ha, 50);
        chk("pwr", 0, power_on_o);
        chk("sd", 0, shutdown_state_o);
        drv(4'he, 10);
        chk("pwr", 1, power_on_o);
        drv(4'h6, 10);
        drv(4'h2, 10);
        $display("seq done");
    endtask
    task t_hard;
        dly = 32'h3e8;
        drv(4'ha, 150);
        chk("pwr", 1, power_on_o);
        drv(4'ha, 70);
        chk("pwr", 0, power_on_o);
        dly = 32'h2;
        drv(4'h6, 10);
        drv(4'h2, 10);
        $display("hard done");
    endtask
    task t_hold;
        drv(4'h9, 250);
        chk("pwr", 1, power_on_o);
        drv(4'hd, 10);
        drv(4'hf, 250);
        chk("pwr", 1, power_on_o);
        chk("disc", 0, disconnect_o);
        drv(4'hb, 10);
        chk("pwr", 0, power_on_o);
        drv(4'h6, 10);
        $display("hold done");
    endtask
    task t_sw;
        dly = 32'h3e8;
        drv(4'ha, 40);
        chk("disc", 1, disconnect_o);
        drv(4'h8, 200);
        chk("pwr", 1, power_on_o);
        chk("sd", 1, shutdown_state_o);
        dly = 32'h2;
        drv(4'h2, 10);
        chk("pwr", 1, power_on_o);
        $display("switch done");
    endtask
    task t_uv;
        drv(4'h3, 10);
        chk("pwr", 0, power_on_o);
        drv(4'h7, 10);
        chk("pwr", 1, power_on_o);
        chk("en", 1, enable_state_o);
        chk("state", 1, state_o == 3'h4);
        drv(4'h3, 10);
        chk("pwr", 0, power_on_o);
        chk("en", 0, enable_state_o);
        drv(4'h6, 10);
        chk("pwr", 1, power_on_o);
        $display("uv done");
    endtask
    initial begin
        drv(4'h2, 20);
        rst_n_i = 1;
        t_seq;
        t_hard;
        t_hold;
        t_sw;
        t_uv;
        stop_test;
    end
    initial begin
        #20000;
        fails++;
        stop_test;
    end
endmodule
